// *** rtl/flash_swap_pkg.sv ***
// constants shared by the flash block swap control logic
package flash_swap_pkg;
    localparam int ADDR_W = 20;
    localparam int BLOCK_BIT = 19;
    localparam int HALF_BIT = 18;
    localparam logic [ADDR_W-1:0] ZERO_BASE = 20'h00000;
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [1:0] CMD_INIT = 2'h0;
    localparam logic [1:0] CMD_SWAP = 2'h1;
    localparam logic [1:0] CMD_REPORT = 2'h2;
    localparam logic [2:0] CHECKS_LOWER = 3'h2;
    localparam logic [2:0] CHECKS_UPPER = 3'h4;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WAIT = 2'b10,
        ST_DONE = 2'b11
    } swap_state_e;
endpackage : flash_swap_pkg

// *** rtl/flash_block_swap_control.sv ***
// swap control: indicator erase check, block mapping, mass erase security
// How it works
// - two equal blocks, either mapped at zero
// - init stores indicator offset for both blocks
// - check drops half bit: four locations upper
// - unerased location: access error or completion error
// - mass erase while swapped may secure device
`timescale 1ns/1ns
module flash_block_swap_control
    import flash_swap_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_cmd_start,
    input wire logic [1:0] i_cmd_code,
    input wire logic [ADDR_W-1:0] i_indicator_addr,
    input wire logic [ADDR_W-1:0] i_cpu_addr,
    input wire logic i_rd_valid,
    input wire logic [31:0] i_rd_data,
    input wire logic i_mass_erase,
    input wire logic i_security_programmed,
    output logic [ADDR_W-1:0] o_phys_addr,
    output logic o_rd_req,
    output logic [ADDR_W-1:0] o_rd_addr,
    output logic o_busy,
    output logic o_done,
    output logic o_access_error_flag,
    output logic o_command_completion_error_flag,
    output logic o_swapped,
    output logic o_secured
);
    swap_state_e state;
    swap_state_e next_state;
    logic [ADDR_W-1:0] indicator;
    logic [1:0] cmd;
    logic [2:0] idx;
    logic [2:0] n_checks;
    logic fail;
    logic swapped;
    logic initialised;

    // the check logic loses the half bit, so an upper indicator also
    // aliases onto the lower half of each block
    wire [ADDR_W-1:0] used_addr = (state == ST_IDLE) ? i_indicator_addr
                                                     : indicator;
    wire upper_half = used_addr[HALF_BIT];
    wire [ADDR_W-1:0] check_addr = {idx[0], (idx[1] ? 1'b0
        : used_addr[HALF_BIT]), used_addr[HALF_BIT-1:0]};
    wire not_erased = i_rd_valid && (i_rd_data != ERASED_WORD);
    wire last_check = (idx == n_checks - 3'h1);
    wire start_ok = i_cmd_start && (state == ST_IDLE)
                    && (i_cmd_code == CMD_INIT || initialised);
    // block select bit inverted when swapped
    wire [ADDR_W-1:0] mapped = {i_cpu_addr[BLOCK_BIT] ^ swapped,
                                i_cpu_addr[BLOCK_BIT-1:0]};

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (start_ok) next_state = ST_READ;
            ST_READ: next_state = ST_WAIT;
            ST_WAIT: if (i_rd_valid) begin
                next_state = last_check ? ST_DONE : ST_READ;
            end
            ST_DONE: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            indicator <= ZERO_BASE;
            cmd <= CMD_INIT;
            idx <= 3'h0;
            n_checks <= CHECKS_LOWER;
            fail <= 1'b0;
        end else if (start_ok) begin
            if (i_cmd_code == CMD_INIT) begin
                indicator <= i_indicator_addr;
            end
            cmd <= i_cmd_code;
            idx <= 3'h0;
            fail <= 1'b0;
            n_checks <= upper_half ? CHECKS_UPPER : CHECKS_LOWER;
        end else if (state == ST_WAIT && i_rd_valid) begin
            idx <= idx + 3'h1;
            fail <= fail | not_erased;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            swapped <= 1'b0;
            o_swapped <= 1'b0;
            initialised <= 1'b0;
            o_access_error_flag <= 1'b0;
            o_command_completion_error_flag <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= (state == ST_DONE);
            if (start_ok) begin
                o_access_error_flag <= 1'b0;
                o_command_completion_error_flag <= 1'b0;
            end else if (state == ST_DONE) begin
                if (fail && cmd == CMD_INIT) begin
                    o_access_error_flag <= 1'b1;
                end else if (fail) begin
                    o_command_completion_error_flag <= 1'b1;
                end else if (cmd == CMD_INIT) begin
                    initialised <= 1'b1;
                end else if (cmd == CMD_SWAP) begin
                    swapped <= ~swapped;
                    o_swapped <= ~swapped;
                end
            end
            // erase puts the blocks back in place, so a repeat unsecures
            if (i_mass_erase) begin
                swapped <= 1'b0;
                o_swapped <= 1'b0;
            end
        end
    end

    // a mass erase while swapped leaves the device secured; the next
    // erase with the blocks in place clears it, so repeating works
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_secured <= 1'b0;
        end else if (i_mass_erase) begin
            o_secured <= swapped | i_security_programmed;
        end else begin
            o_secured <= i_security_programmed | o_secured;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_phys_addr <= ZERO_BASE;
            o_rd_req <= 1'b0;
            o_rd_addr <= ZERO_BASE;
            o_busy <= 1'b0;
        end else begin
            o_phys_addr <= mapped;
            o_rd_req <= (next_state == ST_READ);
            if (state == ST_READ) begin
                o_rd_addr <= check_addr;
            end
            o_busy <= (next_state != ST_IDLE);
        end
    end

    // mass erase clears the swap state only after the secure decision
    // has been taken from the old value
endmodule : flash_block_swap_control

// *** dv/flash_swap_checker.sv ***
// port assertions for the flash block swap control
`timescale 1ns/1ns
module flash_swap_checker
    import flash_swap_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_cmd_start,
    input wire logic [1:0] i_cmd_code,
    input wire logic [ADDR_W-1:0] i_cpu_addr,
    input wire logic i_mass_erase,
    input wire logic [ADDR_W-1:0] o_phys_addr,
    input wire logic o_rd_req,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_swapped,
    input wire logic o_secured
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // skip the cycle where swap flips: mapping may use either side
    a_phys_map: assert property ($past(!i_reset) && $stable(o_swapped) |->
        o_phys_addr == ($past(i_cpu_addr) ^ {o_swapped, {BLOCK_BIT{1'b0}}}))
        else $error("phys map");
    a_swap_done: assert property ($changed(o_swapped) |->
        o_done || $past(i_mass_erase))
        else $error("swap moment");
    a_init_take: assert property (i_cmd_start && i_cmd_code == CMD_INIT &&
        !o_busy && !o_done |=> o_busy) else $error("init take");
    a_busy_reads: assert property ($rose(o_busy) |-> o_rd_req)
        else $error("first read");
    a_read_span: assert property (o_rd_req |-> o_busy ##1 !o_rd_req)
        else $error("read pulse");
    a_done_pulse: assert property (o_done |-> !o_busy ##1 !o_done)
        else $error("done pulse");
    a_erase_secure: assert property (i_mass_erase && o_swapped |=> o_secured)
        else $error("erase secure");
    a_secure_cause: assert property ($rose(o_secured) |-> $past(i_mass_erase))
        else $error("secure cause");
    c_swap: cover property ($rose(o_swapped));
    c_secure: cover property ($rose(o_secured));
    c_read: cover property (o_rd_req);
endmodule : flash_swap_checker

// *** dv/testbench.sv ***
// self-checking bench for the flash block swap control
`timescale 1ns/1ns
module testbench import flash_swap_pkg::*;;
    logic clk = 0, rst = 1, st = 0, rv = 0, me = 0, pend = 0;
    logic [1:0] code = 0;
    logic [ADDR_W-1:0] ind = 0, cpu = 0, bad = 0, pa, ra;
    logic [31:0] rd = 0;
    logic rq, busy, done, acc, cce, swp, sec;
    logic [3:0] q[$], exp;
    int err_count = 0, cmp_count = 0;
    always #5 clk = ~clk;
    flash_block_swap_control i_dut (.i_mclk(clk), .i_reset(rst),
        .i_cmd_start(st), .i_cmd_code(code), .i_indicator_addr(ind),
        .i_cpu_addr(cpu), .i_rd_valid(rv), .i_rd_data(rd), .i_mass_erase(me),
        .i_security_programmed(1'b0), .o_phys_addr(pa), .o_rd_req(rq),
        .o_rd_addr(ra), .o_busy(busy), .o_done(done), .o_access_error_flag(acc),
        .o_command_completion_error_flag(cce), .o_swapped(swp), .o_secured(sec));
    // flash answers one cycle after the read address settles
    always @(posedge clk) begin
        cpu <= ADDR_W'($urandom);
        pend <= rq;
        rv <= pend;
        rd <= (ra == bad) ? 32'h0 : ERASED_WORD;
    end
    // an unexpected done pops nothing and fails on the unknown note
    always @(posedge clk) if (done === 1'b1) begin
        cmp_count++;
        exp = q.size() != 0 ? q.pop_front() : 4'hX;
        if ({acc, cce, swp, sec} !== exp) begin
            err_count++;
            $display("Error flags exp %b seen %b", exp, {acc, cce, swp, sec});
        end
    end
    task automatic cmd(input logic [1:0] c, input logic [ADDR_W-1:0] b,
        input logic [3:0] e);
        int n;
        bad <= b;
        code <= c;
        st <= 1'b1;
        q.push_back(e);
        @(posedge clk) st <= 1'b0;
        for (n = 0; n < 60 && done !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
    endtask : cmd
    task automatic close_out();
        if (q.size() != 0) err_count++;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    initial begin
        #200000;
        err_count++;
        close_out();
    end
    initial begin
        logic [17:0] off;
        void'($urandom(96));
        off = 18'($urandom);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        code <= CMD_SWAP;
        st <= 1'b1;
        @(posedge clk) st <= 1'b0;
        repeat (20) @(posedge clk);
        ind <= {2'b00, off};
        cmd(CMD_INIT, {2'b01, off}, 4'h0);
        ind <= {2'b01, off};
        cmd(CMD_INIT, {2'b10, off}, 4'h8);
        cmd(CMD_INIT, {2'b00, ~off}, 4'h0);
        cmd(CMD_SWAP, {2'b11, off}, 4'h4);
        me <= 1'b1;
        @(posedge clk) me <= 1'b0;
        cmd(CMD_REPORT, {2'b00, ~off}, 4'h0);
        cmd(CMD_SWAP, {2'b00, ~off}, 4'h2);
        me <= 1'b1;
        @(posedge clk) me <= 1'b0;
        cmd(CMD_REPORT, {2'b00, ~off}, 4'h1);
        me <= 1'b1;
        @(posedge clk) me <= 1'b0;
        cmd(CMD_REPORT, {2'b00, ~off}, 4'h0);
        close_out();
    end
endmodule : testbench
bind flash_block_swap_control flash_swap_checker i_chk (.*);
